// *** core/dap_gate_cfg.svh ***
// Constants for the debug access port gate.
// Assumes inclusion by the gate modules only.
`ifndef DAP_GATE_CFG_SVH
`define DAP_GATE_CFG_SVH
// ==========================================
// Reset values and field positions
`define SOFT_DISABLE_RESET 1'b0
`define SOFT_DISABLE_BIT 0
`define LOCK_BIT 0
// ==========================================
// Timing
`define SYNC_STAGES 2
`endif

// *** core/dap_gate_pkg.sv ***
// Types for the debug access port gate.
// Assumes the cfg header sits beside it.
package dap_gate_pkg;
    typedef enum logic [1:0] {
        PORT_OPEN,
        PORT_SOFT_OFF,
        PORT_LOCKED
    } port_state_t;
endpackage

// *** core/dap_link_if.sv ***
// Signals between the gate core and its link-clock side.
// Assumes one instance per gate.
`timescale 1ns/100ps
interface dap_link_if;
    logic enable;
    logic swdio_in;
    logic swdio_out;
    logic swdio_oe;
    logic tdi_in;
    logic tdo_out;
    logic tdo_oe;
    modport core (output enable, input swdio_in, tdi_in, output swdio_out, swdio_oe, tdo_out, tdo_oe);
    modport link (input enable, output swdio_in, tdi_in, input swdio_out, swdio_oe, tdo_out, tdo_oe);
endinterface

// *** core/dap_link_side.sv ***
// Link-clock logic: gates probe pins by a synchronised enable.
// Assumes swclk is the probe clock and may stop outside frames.
`timescale 1ns/100ps
`include "dap_gate_cfg.svh"
module dap_link_side
    import dap_gate_pkg::*;
(
    input wire logic swclk,
    input wire logic reset,
    dap_link_if.link lnk,
    input wire logic swdio_pin_in,
    input wire logic tdi_pin_in,
    output logic swdio_pin_out,
    output logic swdio_pin_oe,
    output logic tdo_pin_out,
    output logic tdo_pin_oe,
    output logic probe_active
);
    logic en_meta_r;
    logic en_sync_r;
    logic swdio_r;
    logic tdi_r;
    logic rst_meta_r;
    logic rst_sync_r;
    // Reset comes from the clk domain, so it is synchronised like the enable
    wire live = en_sync_r & ~rst_sync_r;

    // ==========================================
    // Enable and reset crossing into link domain
    always_ff @(posedge swclk)
    begin
        en_meta_r <= lnk.enable;
        en_sync_r <= en_meta_r;
        rst_meta_r <= reset;
        rst_sync_r <= rst_meta_r;
    end

    // ==========================================
    // Probe sampling, blocked when disabled
    always_ff @(posedge swclk)
    begin
        swdio_r <= live ? swdio_pin_in : 1'b1;
        tdi_r <= live ? tdi_pin_in : 1'b1;
    end

    assign lnk.swdio_in = swdio_r;
    assign lnk.tdi_in = tdi_r;
    assign swdio_pin_out = lnk.swdio_out;
    assign swdio_pin_oe = lnk.swdio_oe & live;
    assign tdo_pin_out = lnk.tdo_out;
    assign tdo_pin_oe = lnk.tdo_oe & live;
    assign probe_active = live;
endmodule

// *** core/debug_port_access_gate.sv ***
// Access gate for the debug access port and its shared pins.
// Assumes debug core on clk, probe on swclk, lock fuse on a pin.
`timescale 1ns/100ps
`include "dap_gate_cfg.svh"
// Overview of operation
// - Lock bit set keeps debug port off while the fuse pin stays high, software cannot override.
// - Lock clear keeps debug port on unless soft-disable is one.
// - Lock is read-only; soft-disable is readable and writable when unlocked.
// - Soft-disable clears to zero on every power-on reset.
// - Soft-disable one turns port off and frees pins for GPIO.
// - Debug port usable after reset without pin function setup.
// - Data/mode pin is high-impedance input after reset by default.
module debug_port_access_gate
    import dap_gate_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic swclk,
    input wire logic lock_fuse,
    input wire logic soft_disable_wr,
    input wire logic soft_disable_wdata,
    input wire logic dbg_swdio_out,
    input wire logic dbg_swdio_oe,
    input wire logic dbg_tdo_out,
    input wire logic dbg_tdo_oe,
    input wire logic swdio_pin_in,
    input wire logic tdi_pin_in,
    output logic lock_status,
    output logic debug_soft_disable,
    output logic port_enabled,
    output logic pins_released,
    output logic dbg_swdio_in,
    output logic dbg_tdi_in,
    output logic swdio_pin_out,
    output logic swdio_pin_oe,
    output logic tdo_pin_out,
    output logic tdo_pin_oe
);
    dap_link_if lnk ();

    logic lock_meta_r;
    logic lock_sync_r;
    logic soft_r;
    logic soft_nxt;
    port_state_t state_r;
    port_state_t state_nxt;
    logic [1:0] sw_meta_r;
    logic [1:0] sw_sync_r;
    logic lock_status_r;
    logic en_r;

    // ==========================================
    // Lock fuse synchroniser
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lock_meta_r <= 1'b1;
            lock_sync_r <= 1'b1;
        end
        else if (clk_en)
        begin
            lock_meta_r <= lock_fuse;
            lock_sync_r <= lock_meta_r;
        end
    end

    // ==========================================
    // Soft-disable control
    // Writes ignored on locked parts; field has no meaning there.
    wire wr_ok = soft_disable_wr & ~lock_sync_r;
    assign soft_nxt = wr_ok ? soft_disable_wdata : soft_r;

    always_ff @(posedge clk)
    begin
        if (reset)
            soft_r <= `SOFT_DISABLE_RESET;
        else if (clk_en)
            soft_r <= soft_nxt;
    end

    // ==========================================
    // Port state
    always_comb
    begin
        case (1'b1)
            lock_sync_r: state_nxt = PORT_LOCKED;
            soft_nxt: state_nxt = PORT_SOFT_OFF;
            default: state_nxt = PORT_OPEN;
        endcase
    end

    // Reset holds the port closed; it opens after release unless locked; no pin setup needed
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= PORT_LOCKED;
            en_r <= 1'b0;
            lock_status_r <= 1'b1;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            en_r <= (state_nxt == PORT_OPEN);
            lock_status_r <= lock_sync_r;
        end
    end

    // ==========================================
    // Link-side signals back into clk domain
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sw_meta_r <= 2'b11;
            sw_sync_r <= 2'b11;
        end
        else if (clk_en)
        begin
            sw_meta_r <= {lnk.swdio_in, lnk.tdi_in};
            sw_sync_r <= sw_meta_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lock_status <= 1'b1;
            debug_soft_disable <= `SOFT_DISABLE_RESET;
            port_enabled <= 1'b0;
            pins_released <= 1'b1;
            dbg_swdio_in <= 1'b1;
            dbg_tdi_in <= 1'b1;
        end
        else if (clk_en)
        begin
            lock_status <= lock_status_r;
            debug_soft_disable <= soft_r;
            port_enabled <= en_r;
            pins_released <= ~en_r;
            dbg_swdio_in <= en_r ? sw_sync_r[1] : 1'b1;
            dbg_tdi_in <= en_r ? sw_sync_r[0] : 1'b1;
        end
    end

    // Drive requests leave here gated; link side gates again
    assign lnk.enable = en_r;
    assign lnk.swdio_out = dbg_swdio_out;
    assign lnk.swdio_oe = dbg_swdio_oe & en_r;
    assign lnk.tdo_out = dbg_tdo_out;
    assign lnk.tdo_oe = dbg_tdo_oe & en_r;

    // ==========================================
    // Link-clock pin logic
    // Pin outputs are combinational from the link side by necessity.
    dap_link_side u_link (
        .swclk(swclk),
        .reset(reset),
        .lnk(lnk.link),
        .swdio_pin_in(swdio_pin_in),
        .tdi_pin_in(tdi_pin_in),
        .swdio_pin_out(swdio_pin_out),
        .swdio_pin_oe(swdio_pin_oe),
        .tdo_pin_out(tdo_pin_out),
        .tdo_pin_oe(tdo_pin_oe),
        .probe_active()
    );
endmodule

// *** tb/debug_port_access_gate_properties.sv ***
// Checker for the debug port gate.
// Assumes binding onto the gate top module.
`timescale 1ns/100ps
module gate_properties(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic lock_fuse,
    input wire logic soft_disable_wr,
    input wire logic soft_disable_wdata,
    input wire logic lock_status,
    input wire logic debug_soft_disable,
    input wire logic port_enabled,
    input wire logic pins_released,
    input wire logic dbg_swdio_in,
    input wire logic dbg_tdi_in
);
    // ==========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr;
        clk_en && soft_disable_wr && !lock_status;
    endsequence
    chk_lock_closed: assert property (lock_status [*3] |-> !port_enabled) else $error("locked port open");
    chk_locked_hold: assert property (lock_status [*3] |-> $stable(debug_soft_disable)) else $error("locked write");
    chk_soft_write: assert property (s_wr |-> ##2 debug_soft_disable == $past(soft_disable_wdata, 2))
        else $error("write lost");
    chk_soft_off: assert property (debug_soft_disable |-> !port_enabled) else $error("soft off ignored");
    chk_pins_free: assert property (pins_released != port_enabled) else $error("pin release wrong");
    // Forced level is registered from en_r with port_enabled, no sync stage delay
    chk_quiet_in: assert property ((!port_enabled) [*4] |-> dbg_swdio_in && dbg_tdi_in) else $error("probe leak");
    chk_open_boot: assert property ($fell(reset) && !lock_fuse |-> ##[1:8] port_enabled) else $error("no open");
    chk_reset_clear: assert property (disable iff (1'b0) reset |=> !debug_soft_disable && !port_enabled)
        else $error("reset state");
endmodule
bind debug_port_access_gate gate_properties i_chk(.clk, .reset, .clk_en, .lock_fuse, .soft_disable_wr,
    .soft_disable_wdata, .lock_status, .debug_soft_disable, .port_enabled, .pins_released, .dbg_swdio_in, .dbg_tdi_in);

// *** tb/dap_probe_model.sv ***
// Probe model: clocks and toggles the link pins.
// Assumes run high marks a frame; data idles on its pullup.
`timescale 1ns/100ps
module dap_probe_model(
    input wire logic run,
    output logic swclk,
    output logic swdio,
    output logic tdi
);
    initial
    begin
        swclk = 0;
        swdio = 1;
        tdi = 1;
        forever
        begin
            #7.5;
            swclk = run & ~swclk;
            swdio = run ? swdio ^ swclk : 1'b1;
            tdi = swdio;
        end
    end
endmodule

// *** tb/test_debug_port_access_gate.sv ***
// Bench for the debug port gate.
// Assumes the probe model drives the link pins.
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("FAIL %s exp %b got %b", n, e, a); end end
module test_debug_port_access_gate
    import dap_gate_pkg::*;
;
    logic clk = 0, reset = 1, clk_en = 1, lock_fuse = 0, soft_disable_wr = 0, soft_disable_wdata = 0;
    logic oe = 0, dout = 0, run = 1, probe_dio;
    logic swclk, lock_status, debug_soft_disable, port_enabled, pins_released, dbg_swdio_in, dbg_tdi_in;
    logic swdio_pin_out, swdio_pin_oe, tdo_pin_out, tdo_pin_oe, tdi_pin_in;
    wire swdio_pin_in = swdio_pin_oe ? swdio_pin_out : probe_dio;
    int err_count = 0, comparisons = 0;
    initial forever #2 clk = ~clk;
    dap_probe_model i_probe(.run, .swclk, .swdio(probe_dio), .tdi(tdi_pin_in));
    debug_port_access_gate i_dut(.clk, .reset, .clk_en, .swclk, .lock_fuse, .soft_disable_wr, .soft_disable_wdata,
        .dbg_swdio_out(dout), .dbg_swdio_oe(oe), .dbg_tdo_out(dout), .dbg_tdo_oe(oe), .swdio_pin_in, .tdi_pin_in,
        .lock_status, .debug_soft_disable, .port_enabled, .pins_released, .dbg_swdio_in, .dbg_tdi_in,
        .swdio_pin_out, .swdio_pin_oe, .tdo_pin_out, .tdo_pin_oe);
    task wr_soft(input logic v);
        @(negedge clk);
        soft_disable_wr = 1;
        soft_disable_wdata = v;
        @(negedge clk);
        soft_disable_wr = 0;
        repeat (3) @(negedge clk);
    endtask
    task wait_open;
        for (int i = 0; i < 12 && port_enabled !== 1'h1; i++) @(negedge clk);
    endtask
    task frame;
        run = 1;
        repeat (12) @(negedge clk);
    endtask
    task t_open;
        wait_open;
        `CHK("port", 1'h1, port_enabled)
        oe = 1;
        frame;
        `CHK("swdio oe", 1'h1, swdio_pin_oe)
        `CHK("swdio wire", 1'h0, swdio_pin_in)
        `CHK("swdio in", 1'h0, dbg_swdio_in)
        `CHK("tdo oe", 1'h1, tdo_pin_oe)
        `CHK("tdo out", 1'h0, tdo_pin_out)
        $display("t_open done");
    endtask
    task t_soft;
        wr_soft(1);
        `CHK("soft", 1'h1, debug_soft_disable)
        `CHK("released", 1'h1, pins_released)
        frame;
        `CHK("swdio oe", 1'h0, swdio_pin_oe)
        `CHK("tdo oe", 1'h0, tdo_pin_oe)
        `CHK("swdio in", 1'h1, dbg_swdio_in)
        wr_soft(0);
        `CHK("soft", 1'h0, debug_soft_disable)
        wait_open;
        `CHK("port", 1'h1, port_enabled)
        $display("t_soft done");
    endtask
    task t_lock;
        lock_fuse = 1;
        repeat (6) @(negedge clk);
        `CHK("lock", 1'h1, lock_status)
        `CHK("port", 1'h0, port_enabled)
        wr_soft(1);
        `CHK("soft", 1'h0, debug_soft_disable)
        lock_fuse = 0;
        repeat (6) @(negedge clk);
        $display("t_lock done");
    endtask
    task t_reset;
        wr_soft(1);
        reset = 1;
        repeat (12) @(negedge clk);
        `CHK("soft", 1'h0, debug_soft_disable)
        `CHK("swdio oe", 1'h0, swdio_pin_oe)
        reset = 0;
        wait_open;
        `CHK("port", 1'h1, port_enabled)
        $display("t_reset done");
    endtask
    task final_report;
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_count++;
        final_report;
    end
    initial
    begin
        repeat (12) @(negedge clk);
        reset = 0;
        t_open;
        t_soft;
        t_lock;
        t_reset;
        final_report;
    end
endmodule
